// *** design/fsp_pkg.sv ***
// fsp_pkg: constants and carrier types for the two-channel fan speed pwm.
// assumes a single 40 MHz clock and byte-wide runtime register access.
package fsp_pkg;

	// system clock rate in Hz
	localparam longint CLK_HZ = 40000000;

	// runtime register offsets from the runtime base address
	localparam logic [7:0] OFS_FAN_ONE  = 8'h56;
	localparam logic [7:0] OFS_FAN_TWO  = 8'h57;
	localparam logic [7:0] OFS_FAN_CTRL = 8'h58;

	// per-fan setting register fields
	localparam int BIT_FORCE_HIGH = 0;
	localparam int BIT_DUTY_LO    = 1;
	localparam int BIT_DUTY_HI    = 6;
	localparam int BIT_CLK_SEL    = 7;

	// shared fan control register fields, fan one then fan two
	localparam int BIT_SRC_ONE  = 0;
	localparam int BIT_SRC_TWO  = 1;
	localparam int BIT_MULT_ONE = 2;
	localparam int BIT_MULT_TWO = 3;
	localparam int CTRL_W       = 4;

	// reset values
	localparam logic [7:0]        RST_FAN_SETTING = 8'h00;
	localparam logic [CTRL_W-1:0] RST_FAN_CTRL    = 4'h0;
	localparam logic [7:0]        RDATA_NONE      = 8'h00;

	// output rates in Hz without multiplication
	localparam longint F_FAST_LO = 15625;
	localparam longint F_FAST_HI = 23438;
	localparam longint F_SLOW_LO = 40;
	localparam longint F_SLOW_HI = 60;

	// steps in one output period and phase accumulator width
	localparam int     DUTY_W  = 6;
	localparam longint STEPS   = 64;
	localparam int     ACC_W   = 24;
	localparam logic [DUTY_W-1:0] STEP_LAST = 6'h3f;

	// one fan's configuration as seen by its channel
	typedef struct packed {
		logic              force_high_override_bit;
		logic [DUTY_W-1:0] duty_cycle_field;
		logic              clk_sel;
		logic              clk_mult;
		logic              clk_src;
	} fsp_chan_cfg_t;

	// accumulator increment giving 64 steps per output period
	function automatic logic [ACC_W-1:0] fsp_step_inc(
		input logic mult,
		input logic src,
		input logic sel
	);
		logic [63:0] f;
		logic [63:0] inc;
		f = 64'(src ? (sel ? F_SLOW_HI : F_SLOW_LO)
		            : (sel ? F_FAST_HI : F_FAST_LO));
		if (mult) begin
			f = f << 1;
		end
		inc = (f * 64'(STEPS) * (64'h1 << ACC_W)) / 64'(CLK_HZ);
		return inc[ACC_W-1:0];
	endfunction

endpackage

// *** design/fsp_pwm_chan.sv ***
// fsp_pwm_chan: one fan output, a 64-step period counter driven by a
// fractional rate accumulator. assumes configuration from the same clock.
`timescale 1ns/100ps
module fsp_pwm_chan (
	// clock and resets
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  hard_reset_i,
	// configuration
	input  wire fsp_pkg::fsp_chan_cfg_t cfg_i,
	// fan drive
	output logic                       pwm_o
);

	typedef struct packed {
		logic [fsp_pkg::ACC_W-1:0]  acc;
		logic [fsp_pkg::DUTY_W-1:0] step;
		logic [fsp_pkg::DUTY_W-1:0] duty;
		logic                       pwm;
	} fsp_chan_state_t;

	fsp_chan_state_t           state;
	fsp_chan_state_t           next_state;
	logic [fsp_pkg::ACC_W:0]   sum;
	logic [fsp_pkg::ACC_W-1:0] inc;

	always_comb begin
		next_state = state;
		// rate from multiplier, source and clock select
		inc = fsp_pkg::fsp_step_inc(cfg_i.clk_mult, cfg_i.clk_src,
			cfg_i.clk_sel);
		sum = {1'b0, state.acc} + {1'b0, inc};
		next_state.acc = sum[fsp_pkg::ACC_W-1:0];
		if (sum[fsp_pkg::ACC_W]) begin
			next_state.step = state.step + 6'h01;
			// new duty only at the period boundary
			if (state.step == fsp_pkg::STEP_LAST) begin
				next_state.duty = cfg_i.duty_cycle_field;
			end
		end
		if (cfg_i.force_high_override_bit) begin
			next_state.pwm = 1'b1;
		end else begin
			// zero duty never exceeds step, so it stays low
			next_state.pwm = (next_state.step < next_state.duty);
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= '0;
		end else if (hard_reset_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pwm_o = state.pwm;

endmodule

// *** design/fsp_fan_speed_pwm.sv ***
// fsp_fan_speed_pwm: two fan speed pwm outputs with their runtime
// registers at the per-fan and shared fan control offsets.
// assumes the runtime base decode is done outside; offsets arrive on
// io_addr_i with byte strobes from logic on the same clock.
//
// Behaviour
// - two independent fan outputs, driven low as outputs after power-on and hard reset.
// - force-high bit zero of a fan register holds that output high.
// - with override clear and zero duty the output stays low.
// - nonzero duty N gives high for N/64 of each period.
// - six-bit duty field sits in bits six down to one.
// - per-fan clock select sits at bit seven of its register.
// - clock multiplier bits are control bits two and three.
// - clock source select bits are control bits zero and one.
// - unmultiplied rates 15.625k/23.438kHz or 40/60Hz by source and select.
// - multiplied rates 31.25k/46.876kHz or 80/120Hz by source and select.
// - fan registers decode at offsets 0x56 and 0x57.
// - fan pins are never wakeup sources on standby power.
// - multiplier one doubles the source rate, zero leaves it.
`timescale 1ns/100ps
module fsp_fan_speed_pwm #(
	parameter int NUM_FANS = 2
) (
	// clock and resets
	input  wire logic                clk_i,
	input  wire logic                reset_n_i,
	input  wire logic                hard_reset_i,
	// runtime register access
	input  wire logic [7:0]          io_addr_i,
	input  wire logic                io_wr_i,
	input  wire logic                io_rd_i,
	input  wire logic [7:0]          io_wdata_i,
	output logic      [7:0]          io_rdata_o,
	output logic                     io_rvalid_o,
	// fan speed pins
	output logic      [NUM_FANS-1:0] fan_pwm_o,
	output logic      [NUM_FANS-1:0] fan_oe_n_o
);

	// one-hot select of the runtime register an offset lands on
	typedef struct packed {
		logic fan_one;
		logic fan_two;
		logic fan_ctrl;
	} fsp_sel_t;

	typedef struct packed {
		logic [NUM_FANS-1:0][7:0]     fan_setting;
		logic [fsp_pkg::CTRL_W-1:0]   fan_ctrl;
		logic [7:0]                   rdata;
		logic                         rvalid;
	} fsp_regs_t;

	fsp_regs_t                      regs;
	fsp_regs_t                      next_regs;
	fsp_pkg::fsp_chan_cfg_t [NUM_FANS-1:0] chan_cfg;
	logic [NUM_FANS-1:0]            chan_pwm;
	fsp_sel_t                       sel;

	// offset match, used by both the write and the read decode
	function automatic logic fsp_hit(
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return addr == ofs;
	endfunction

	// offset decode shared by writes and reads
	function automatic fsp_sel_t fsp_decode(
		input logic [7:0] addr
	);
		fsp_sel_t s;
		s = '0;
		if (fsp_hit(addr, fsp_pkg::OFS_FAN_ONE)) begin
			s.fan_one = 1'b1;
		end else if (fsp_hit(addr, fsp_pkg::OFS_FAN_TWO)) begin
			s.fan_two = 1'b1;
		end else if (fsp_hit(addr, fsp_pkg::OFS_FAN_CTRL)) begin
			s.fan_ctrl = 1'b1;
		end
		return s;
	endfunction

	// value a read returns; unmapped offsets read as zero
	function automatic logic [7:0] fsp_read_word(
		input fsp_sel_t  s,
		input fsp_regs_t r
	);
		logic [7:0] w;
		w = fsp_pkg::RDATA_NONE;
		if (s.fan_one) begin
			w = r.fan_setting[0];
		end else if (s.fan_two) begin
			w = r.fan_setting[1];
		end else if (s.fan_ctrl) begin
			// divisor bits belong to the tachometer, read as zero here
			w = {4'h0, r.fan_ctrl};
		end
		return w;
	endfunction

	// one channel's configuration: its setting byte plus the shared
	// control bits, fan i using source bit i and multiplier bit i+2
	function automatic fsp_pkg::fsp_chan_cfg_t fsp_chan_fields(
		input logic [7:0]                 setting,
		input logic [fsp_pkg::CTRL_W-1:0] ctrl,
		input int                         idx
	);
		fsp_pkg::fsp_chan_cfg_t c;
		c = '0;
		c.force_high_override_bit =
			setting[fsp_pkg::BIT_FORCE_HIGH];
		c.duty_cycle_field =
			setting[fsp_pkg::BIT_DUTY_HI:fsp_pkg::BIT_DUTY_LO];
		c.clk_sel  = setting[fsp_pkg::BIT_CLK_SEL];
		c.clk_mult = ctrl[fsp_pkg::BIT_MULT_ONE + idx];
		c.clk_src  = ctrl[fsp_pkg::BIT_SRC_ONE + idx];
		return c;
	endfunction

	assign sel = fsp_decode(io_addr_i);

	// register file; a read in the same cycle as a write returns old data
	always_comb begin
		next_regs = regs;
		next_regs.rvalid = 1'b0;
		if (io_wr_i) begin
			if (sel.fan_one) begin
				next_regs.fan_setting[0] = io_wdata_i;
			end else if (sel.fan_two) begin
				next_regs.fan_setting[1] = io_wdata_i;
			end else if (sel.fan_ctrl) begin
				next_regs.fan_ctrl = io_wdata_i[fsp_pkg::CTRL_W-1:0];
			end
		end
		if (io_rd_i) begin
			next_regs.rvalid = 1'b1;
			next_regs.rdata  = fsp_read_word(sel, regs);
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			regs.fan_setting <= {NUM_FANS{fsp_pkg::RST_FAN_SETTING}};
			regs.fan_ctrl    <= fsp_pkg::RST_FAN_CTRL;
			regs.rdata       <= fsp_pkg::RDATA_NONE;
			regs.rvalid      <= 1'b0;
		end else if (hard_reset_i) begin
			regs.fan_setting <= {NUM_FANS{fsp_pkg::RST_FAN_SETTING}};
			regs.fan_ctrl    <= fsp_pkg::RST_FAN_CTRL;
			regs.rdata       <= fsp_pkg::RDATA_NONE;
			regs.rvalid      <= 1'b0;
		end else begin
			regs <= next_regs;
		end
	end

	// one independent generator per fan, each fed its own fields
	generate
		for (genvar g = 0; g < NUM_FANS; g++) begin : g_chan
			assign chan_cfg[g] = fsp_chan_fields(regs.fan_setting[g],
				regs.fan_ctrl, g);
			fsp_pwm_chan u_chan (
				.clk_i        (clk_i),
				.reset_n_i    (reset_n_i),
				.hard_reset_i (hard_reset_i),
				.cfg_i        (chan_cfg[g]),
				.pwm_o        (chan_pwm[g])
			);
		end
	endgenerate

	// pins are pure outputs; nothing here samples them, so no wake path
	assign fan_pwm_o   = chan_pwm;
	assign fan_oe_n_o  = '0;
	assign io_rdata_o  = regs.rdata;
	assign io_rvalid_o = regs.rvalid;

endmodule

// *** bench/fsp_assertions.sv ***
// fsp_assertions: port timing checks for the fan pwm block.
// assumes one clock domain and the byte register strobes.
`timescale 1ns/100ps
module fsp_assertions #(
	parameter int NUM_FANS = 2
) (
	input wire logic                clk_i,
	input wire logic                reset_n_i,
	input wire logic                hard_reset_i,
	input wire logic [7:0]          io_addr_i,
	input wire logic                io_wr_i,
	input wire logic                io_rd_i,
	input wire logic [7:0]          io_wdata_i,
	input wire logic [7:0]          io_rdata_o,
	input wire logic                io_rvalid_o,
	input wire logic [NUM_FANS-1:0] fan_pwm_o,
	input wire logic [NUM_FANS-1:0] fan_oe_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	oe_drive_a: assert property (fan_oe_n_o == '0)
		else $error("fan pin not driven");
	hard_low_a: assert property (hard_reset_i |=> fan_pwm_o == '0)
		else $error("fan high after hard reset");
	force_one_a: assert property (io_wr_i && io_addr_i == 8'h56
		&& io_wdata_i[0] && !hard_reset_i ##1 !io_wr_i && !hard_reset_i
		|=> fan_pwm_o[0]) else $error("fan one not forced");
	force_two_a: assert property (io_wr_i && io_addr_i == 8'h57
		&& io_wdata_i[0] && !hard_reset_i ##1 !io_wr_i && !hard_reset_i
		|=> fan_pwm_o[1]) else $error("fan two not forced");
	read_ack_a: assert property (io_rd_i && !hard_reset_i |=> io_rvalid_o)
		else $error("read not acknowledged");
	no_ack_a: assert property (!io_rd_i |=> !io_rvalid_o)
		else $error("stray read valid");
	read_hole_a: assert property (io_rd_i && !hard_reset_i
		&& !(io_addr_i inside {[8'h56:8'h58]}) |=> io_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	read_back_a: assert property (io_wr_i && io_addr_i == 8'h57
		&& !hard_reset_i ##1 !io_wr_i && !hard_reset_i ##1 io_rd_i
		&& io_addr_i == 8'h57 && !hard_reset_i
		|=> io_rdata_o == $past(io_wdata_i, 3)) else $error("readback");
	cover property (fan_pwm_o == 2'h3);
	cover property (io_rvalid_o && io_rdata_o == 8'h00);
	cover property ($rose(fan_pwm_o[1]));
endmodule

bind fsp_fan_speed_pwm fsp_assertions #(.NUM_FANS(NUM_FANS))
	i_fsp_assertions (.clk_i, .reset_n_i, .hard_reset_i, .io_addr_i,
	.io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o,
	.fan_pwm_o, .fan_oe_n_o);

// *** bench/fsp_fan_model.sv ***
// fsp_fan_model: a fan input timing each pwm period and its high time.
// assumes the drive level is sampled on the bench clock.
`timescale 1ns/100ps
module fsp_fan_model (
	// clock
	input  wire logic        clk_i,
	// drive from the block
	input  wire logic        pwm_i,
	// last full period and its high time, in clocks
	output logic      [31:0] hi_o,
	output logic      [31:0] per_o
);
	logic        last;
	logic [31:0] cnt;
	logic [31:0] hi;
	initial {last, cnt, hi, hi_o, per_o} = '0;
	always @(posedge clk_i) begin
		last <= pwm_i;
		if (pwm_i && !last) begin
			per_o <= cnt;
			hi_o <= hi;
			cnt <= 32'h1;
			hi <= 32'h1;
		end else begin
			cnt <= cnt + 32'h1;
			hi <= hi + 32'(pwm_i);
		end
	end
endmodule

// *** bench/testbench.sv ***
// testbench: programs the fan registers and times both outputs.
// assumes a fan model on each output.
`timescale 1ns/100ps
module testbench;
	logic        clk_i = 0, reset_n_i = 0, hard_reset_i = 0;
	logic        io_wr_i = 0, io_rd_i = 0, io_rvalid_o;
	logic [7:0]  io_addr_i = 0, io_wdata_i = 0, io_rdata_o;
	logic [1:0]  fan_pwm_o, fan_oe_n_o;
	logic [31:0] hi_o [2];
	logic [31:0] per_o [2];
	int          n_fail = 0, n_checks = 0;
	fsp_fan_speed_pwm i_fsp_fan_speed_pwm (.clk_i, .reset_n_i,
		.hard_reset_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
		.io_rdata_o, .io_rvalid_o, .fan_pwm_o, .fan_oe_n_o);
	for (genvar g = 0; g < 2; g++) begin : fan
		fsp_fan_model i_fsp_fan_model (.clk_i, .pwm_i(fan_pwm_o[g]),
			.hi_o(hi_o[g]), .per_o(per_o[g]));
	end
	task automatic chk(string nm, logic [31:0] e, s, int tol = 0);
		n_checks++;
		if ((s + tol >= e && s <= e + tol) !== 1'b1) begin
			n_fail++;
			$display("Error %s expected %0d seen %0d", nm, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, d);
		@(negedge clk_i);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1;
		@(negedge clk_i);
		io_wr_i = 0;
	endtask
	task automatic rd(logic [7:0] a, e);
		@(negedge clk_i);
		io_addr_i = a;
		io_rd_i = 1;
		@(negedge clk_i);
		io_rd_i = 0;
		chk("rvalid", 1, io_rvalid_o);
		chk("rdata", e, io_rdata_o);
	endtask
	task automatic t_reset;
		chk("oe_n", 0, fan_oe_n_o);
		chk("pwm", 0, fan_pwm_o);
		rd(8'h56, 8'h00);
		wr(8'h57, 8'h01);
		repeat (2) @(negedge clk_i);
		chk("force", 2'h2, fan_pwm_o);
		hard_reset_i = 1;
		@(negedge clk_i);
		hard_reset_i = 0;
		@(negedge clk_i);
		chk("hard", 0, fan_pwm_o);
		rd(8'h57, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_regs;
		wr(8'h56, 8'ha5);
		wr(8'h58, 8'hff);
		wr(8'h55, 8'hff);
		wr(8'h57, 8'h5a);
		rd(8'h57, 8'h5a);
		rd(8'h56, 8'ha5);
		rd(8'h58, 8'h0f);
		rd(8'h55, 8'h00);
		$display("test registers done");
	endtask
	task automatic t_rate;
		real p;
		int  d;
		for (int m = 0; m < 4; m++) begin
			p = 4.0e7 / ((m[0] ? 23438.0 : 15625.0) * (m[1] ? 2 : 1));
			d = m * 20 + 3;
			wr(8'h58, {4'h0, m[1], m[1], 2'b00});
			wr(8'h56, {m[0], 6'(d), 1'b0});
			wr(8'h57, {m[0], 6'(64 - d), 1'b0});
			repeat ($rtoi(4 * p)) @(negedge clk_i);
			for (int f = 0; f < 2; f++) begin
				chk("period", $rtoi(p + 0.5), per_o[f], 2);
				chk("high", $rtoi((f ? 64 - d : d) * p / 64 + 0.5), hi_o[f], 2);
			end
		end
		$display("test rates done");
	endtask
	task automatic t_slow;
		int h;
		h = 0;
		wr(8'h56, 8'h82);
		repeat (2000) @(negedge clk_i);
		while (fan_pwm_o[0] && h < 2000) begin
			@(negedge clk_i);
			h++;
		end
		while (!fan_pwm_o[0] && h < 4000) begin
			@(negedge clk_i);
			h++;
		end
		h = 0;
		wr(8'h58, 8'h05);
		while (fan_pwm_o[0] && h < 8000) begin
			@(negedge clk_i);
			h++;
		end
		chk("slow high", 4231, h, 210);
		$display("test slow rate done");
	endtask
	task automatic t_level;
		int h0, h1;
		h0 = 0;
		h1 = 0;
		wr(8'h56, 8'h7f);
		wr(8'h57, 8'h80);
		repeat (2600) @(negedge clk_i);
		repeat (3000) @(negedge clk_i) begin
			h0 += fan_pwm_o[0];
			h1 += fan_pwm_o[1];
		end
		chk("forced high", 3000, h0);
		chk("zero duty", 0, h1);
		$display("test levels done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		repeat (20) @(negedge clk_i);
		reset_n_i = 1;
		t_reset;
		t_regs;
		t_rate;
		t_slow;
		t_level;
		conclude;
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		n_fail++;
		conclude;
	end
endmodule
